// >>> nib_exec.sv
// Execute unit for accumulator, memory, arithmetic, compare, load/store and
// pointer instructions of a 4-bit core; holds the working RAM itself.
// Assumes a fetch stage presents one byte at a time with valid/ready and a
// program ROM that answers a registered address in the next cycle.
//
// Function
// - Opcode C0 clears accumulator, sets zero_bit
// - E1 clears carry_bit, F1 sets carry_bit
// - EB complements accumulator, updates zero_bit
// - 0E/0F step accumulator, update both flags
// - 01 rotates accumulator left through carry_bit
// - 03 copies, 0D swaps accumulator and aux
// - 2E/2F step RAM nibble, both flags
// - Bit set/clear in RAM; clear updates zero
// - 60/20 add RAM (and carry) to accumulator
// - E6 adds six, EA adds ten; zero only
// - XOR, AND, OR with RAM; zero_bit
// - compare_ram: RAM plus inverted accumulator plus one
// - Two-byte compares against immediate nibble
// - Cx loads immediate into accumulator, zero_bit
// - 02 stores, 21 loads accumulator from RAM
// - A0-A7 swap RAM, OR into ptr_high
// - A0 swap, zero_bit from ptr_high
// - FE/FF swap RAM, step ptr_low, zero
// - 63 loads ROM byte into aux:accumulator
// - 8x clears ptr_high, loads ptr_low
// - 4x loads ptr_high, flags untouched
// - EE/EF step ptr_low, update zero_bit
`default_nettype none

module nib_exec
   import nib_pkg::*;
#(
   parameter int RAM_DEPTH = 256                    // Nibbles of working RAM
)(
   input wire logic clk_i,                          // 10 MHz system clock
   input wire logic reset_n_i,                      // Synchronous reset, active low
   input wire logic instr_valid_i,                  // Instruction byte present
   input wire logic [7:0] instr_i,                  // Instruction byte
   output logic instr_ready_o,                      // Byte can be taken this cycle
   input wire logic [PAGE_W-1:0] rom_page_i,        // Current program page
   output logic [PAGE_W+ROM_W-1:0] rom_addr_o,      // Table lookup address
   input wire logic [ROM_W-1:0] rom_data_i,         // ROM word, one cycle later
   output logic [3:0] acc_o,                        // Main operand register
   output logic [3:0] aux_o,                        // Auxiliary register
   output logic [3:0] ptr_high_o,                   // ptr_high
   output logic [3:0] ptr_low_o,                    // ptr_low
   output logic carry_bit_o,                        // carry_bit
   output logic zero_bit_o                          // zero_bit
);

   // Architectural state
   logic [3:0] acc_r, acc_nxt;                      // Main operand register
   logic [3:0] aux_r, aux_nxt;                      // Auxiliary register
   logic [3:0] ptr_high_r, ptr_high_nxt;            // Upper pointer nibble
   logic [3:0] ptr_low_r, ptr_low_nxt;              // Lower pointer nibble
   logic carry_r, carry_nxt;                        // carry_bit
   logic zero_r, zero_nxt;                          // zero_bit

   // Sequencer state
   nib_state_t state_r, state_nxt;                  // Byte/cycle phase
   logic lookup_r, lookup_nxt;                      // Hold cycle loads ROM word
   logic [PAGE_W+ROM_W-1:0] rom_addr_r, rom_addr_nxt;  // Registered ROM address

   // Working RAM, addressed by ram_pointer
   logic [3:0] ram_mem [RAM_DEPTH];                 // Nibble store
   logic ram_we;                                    // Write this cycle
   logic [3:0] ram_wd;                              // Write data
   logic [3:0] ram_q;                               // Nibble at ram_pointer
   logic [PTR_W-1:0] ram_pointer;                   // {ptr_high, ptr_low}

   // Shared adder
   nib_alu_if alu_bus ();                           // Adder operands and result
   logic take;                                      // Byte accepted this cycle
   logic [3:0] logic_res;                           // Bitwise result scratch
   logic [3:0] mask;                                // One-hot bit select

   nib_alu u_alu (
      .bus (alu_bus.unit)
   );

   assign ram_pointer = {ptr_high_r, ptr_low_r};
   assign ram_q = ram_mem[ram_pointer];

   // Bytes are taken while no second cycle is running
   assign instr_ready_o = (state_r != NIB_ST_HOLD);
   assign take = instr_valid_i && instr_ready_o;

   // Outputs come straight from flip-flops
   assign acc_o = acc_r;
   assign aux_o = aux_r;
   assign ptr_high_o = ptr_high_r;
   assign ptr_low_o = ptr_low_r;
   assign carry_bit_o = carry_r;
   assign zero_bit_o = zero_r;
   assign rom_addr_o = rom_addr_r;

   // Decode and next-value computation
   always_comb begin
      acc_nxt = acc_r;
      aux_nxt = aux_r;
      ptr_high_nxt = ptr_high_r;
      ptr_low_nxt = ptr_low_r;
      carry_nxt = carry_r;
      zero_nxt = zero_r;
      state_nxt = state_r;
      lookup_nxt = 1'b0;
      rom_addr_nxt = rom_addr_r;
      ram_we = 1'b0;
      ram_wd = acc_r;
      alu_bus.a = acc_r;
      alu_bus.b = 4'h0;
      alu_bus.cin = 1'b0;
      logic_res = 4'h0;
      mask = 4'h1 << instr_i[1:0];
      case (state_r)
         NIB_ST_IDLE: begin
            if (take) begin
               casez (instr_i)
                  // Same effect as the load-immediate form with zero
                  OP_ZERO_ACC: begin
                     acc_nxt = 4'h0;
                     zero_nxt = 1'b1;
                  end
                  OP_ZERO_CARRY: begin
                     carry_nxt = 1'b0;
                  end
                  OP_SET_CARRY: begin
                     carry_nxt = 1'b1;
                  end
                  OP_INVERT_ACC: begin
                     acc_nxt = ~acc_r;
                     zero_nxt = (acc_r == 4'hF);
                  end
                  // Decrement adds all-ones; carry means no borrow
                  OP_ACC_PLUS_ONE, OP_ACC_MINUS_ONE: begin
                     alu_bus.b = instr_i[0] ? 4'hF : 4'h0;
                     alu_bus.cin = ~instr_i[0];
                     acc_nxt = alu_bus.sum;
                     carry_nxt = alu_bus.cout;
                     zero_nxt = (alu_bus.sum == 4'h0);
                  end
                  OP_ROTATE_ACC_LEFT: begin
                     acc_nxt = {acc_r[2:0], carry_r};
                     carry_nxt = acc_r[3];
                     zero_nxt = ({acc_r[2:0], carry_r} == 4'h0);
                  end
                  OP_COPY_ACC_TO_AUX: begin
                     aux_nxt = acc_r;
                  end
                  OP_SWAP_ACC_AUX: begin
                     aux_nxt = acc_r;
                     acc_nxt = aux_r;
                  end
                  OP_RAM_PLUS_ONE, OP_RAM_MINUS_ONE: begin
                     alu_bus.a = ram_q;
                     alu_bus.b = instr_i[0] ? 4'hF : 4'h0;
                     alu_bus.cin = ~instr_i[0];
                     ram_we = 1'b1;
                     ram_wd = alu_bus.sum;
                     carry_nxt = alu_bus.cout;
                     zero_nxt = (alu_bus.sum == 4'h0);
                  end
                  OP_RAM_BIT_SET: begin
                     ram_we = 1'b1;
                     ram_wd = ram_q | mask;
                  end
                  OP_RAM_BIT_CLEAR: begin
                     logic_res = ram_q & ~mask;
                     ram_we = 1'b1;
                     ram_wd = logic_res;
                     zero_nxt = (logic_res == 4'h0);
                  end
                  OP_SUM_RAM, OP_SUM_RAM_CARRY: begin
                     alu_bus.b = ram_q;
                     alu_bus.cin = instr_i[6] ? 1'b0 : carry_r;
                     acc_nxt = alu_bus.sum;
                     carry_nxt = alu_bus.cout;
                     zero_nxt = (alu_bus.sum == 4'h0);
                  end
                  // Carry out is dropped on purpose: only zero_bit moves
                  OP_BCD_FIX_ADD, OP_BCD_FIX_SUB: begin
                     alu_bus.b = (instr_i == OP_BCD_FIX_ADD) ? BCD_ADD_K : BCD_SUB_K;
                     acc_nxt = alu_bus.sum;
                     zero_nxt = (alu_bus.sum == 4'h0);
                  end
                  OP_XOR_RAM, OP_AND_RAM, OP_OR_RAM: begin
                     if (instr_i == OP_XOR_RAM) begin
                        logic_res = acc_r ^ ram_q;
                     end else if (instr_i == OP_AND_RAM) begin
                        logic_res = acc_r & ram_q;
                     end else begin
                        logic_res = acc_r | ram_q;
                     end
                     acc_nxt = logic_res;
                     zero_nxt = (logic_res == 4'h0);
                  end
                  // Register is left alone; only the flags record the order
                  OP_COMPARE_RAM: begin
                     alu_bus.a = ram_q;
                     alu_bus.b = ~acc_r;
                     alu_bus.cin = 1'b1;
                     carry_nxt = alu_bus.cout;
                     zero_nxt = (alu_bus.sum == 4'h0);
                  end
                  OP_COMPARE_PREFIX: begin
                     state_nxt = NIB_ST_IMM;
                  end
                  OP_LOAD_IMM: begin
                     acc_nxt = instr_i[3:0];
                     zero_nxt = (instr_i[3:0] == 4'h0);
                  end
                  OP_STORE_RAM: begin
                     ram_we = 1'b1;
                     ram_wd = acc_r;
                  end
                  OP_LOAD_RAM: begin
                     acc_nxt = ram_q;
                     zero_nxt = (ram_q == 4'h0);
                  end
                  // With a zero field this is the plain exchange
                  OP_SWAP_RAM_OR_HIGH: begin
                     logic_res = ptr_high_r | {1'b0, instr_i[2:0]};
                     ram_we = 1'b1;
                     ram_wd = acc_r;
                     acc_nxt = ram_q;
                     ptr_high_nxt = logic_res;
                     zero_nxt = (logic_res == 4'h0);
                     state_nxt = NIB_ST_HOLD;
                  end
                  // Pointer moves after the exchange used the old address
                  OP_SWAP_RAM_STEP_UP, OP_SWAP_RAM_STEP_DOWN: begin
                     alu_bus.a = ptr_low_r;
                     alu_bus.b = instr_i[0] ? 4'hF : 4'h0;
                     alu_bus.cin = ~instr_i[0];
                     ram_we = 1'b1;
                     ram_wd = acc_r;
                     acc_nxt = ram_q;
                     ptr_low_nxt = alu_bus.sum;
                     zero_nxt = (alu_bus.sum == 4'h0);
                     state_nxt = NIB_ST_HOLD;
                  end
                  OP_ROM_LOOKUP: begin
                     rom_addr_nxt = {rom_page_i, aux_r, acc_r};
                     lookup_nxt = 1'b1;
                     state_nxt = NIB_ST_HOLD;
                  end
                  OP_PTR_ZERO_LOAD: begin
                     ptr_high_nxt = 4'h0;
                     ptr_low_nxt = instr_i[3:0];
                  end
                  OP_PTR_HIGH_LOAD: begin
                     ptr_high_nxt = instr_i[3:0];
                  end
                  OP_PTR_LOW_UP, OP_PTR_LOW_DOWN: begin
                     alu_bus.a = ptr_low_r;
                     alu_bus.b = instr_i[0] ? 4'hF : 4'h0;
                     alu_bus.cin = ~instr_i[0];
                     ptr_low_nxt = alu_bus.sum;
                     zero_nxt = (alu_bus.sum == 4'h0);
                  end
                  // Opcodes outside these groups pass as one-cycle no-ops
                  default: begin
                     state_nxt = NIB_ST_IDLE;
                  end
               endcase
            end
         end
         // Second byte carries the immediate and the target select
         NIB_ST_IMM: begin
            if (take) begin
               state_nxt = NIB_ST_IDLE;
               if (instr_i[CMP_SEL_BIT]) begin
                  zero_nxt = (ptr_low_r == instr_i[3:0]);
               end else begin
                  alu_bus.a = instr_i[3:0];
                  alu_bus.b = ~acc_r;
                  alu_bus.cin = 1'b1;
                  carry_nxt = alu_bus.cout;
                  zero_nxt = (alu_bus.sum == 4'h0);
               end
            end
         end
         // Stall cycle; a table lookup lands here
         NIB_ST_HOLD: begin
            state_nxt = NIB_ST_IDLE;
            if (lookup_r) begin
               aux_nxt = rom_data_i[7:4];
               acc_nxt = rom_data_i[3:0];
            end
         end
         default: begin
            state_nxt = NIB_ST_IDLE;
         end
      endcase
   end

   // Register update; RAM keeps contents across reset
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_r <= ACC_RST;
         aux_r <= AUX_RST;
         ptr_high_r <= PTR_HIGH_RST;
         ptr_low_r <= PTR_LOW_RST;
         carry_r <= CARRY_RST;
         zero_r <= ZERO_RST;
         state_r <= NIB_ST_IDLE;
         lookup_r <= 1'b0;
         rom_addr_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         aux_r <= aux_nxt;
         ptr_high_r <= ptr_high_nxt;
         ptr_low_r <= ptr_low_nxt;
         carry_r <= carry_nxt;
         zero_r <= zero_nxt;
         state_r <= state_nxt;
         lookup_r <= lookup_nxt;
         rom_addr_r <= rom_addr_nxt;
      end
   end

   // Working RAM write port, no reset by design
   always_ff @(posedge clk_i) begin
      if (ram_we && reset_n_i) begin
         ram_mem[ram_pointer] <= ram_wd;
      end
   end

endmodule : nib_exec

`default_nettype wire

// >>> nib_pkg.sv
// Opcodes, constants and reset values of the nibble execute block.
// Assumes a single clock domain; nib_exec, nib_alu and nib_exec_props import the whole package.
`default_nettype none

package nib_pkg;

   // Datapath widths
   localparam int NIB_W = 4;                     // Operand width
   localparam int PTR_W = 8;                     // Full ram_pointer width
   localparam int PAGE_W = 4;                    // ROM page bits above the table index
   localparam int ROM_W = 8;                     // ROM word width

   // Reset values
   localparam logic [3:0] ACC_RST = 4'h0;        // Main operand register
   localparam logic [3:0] AUX_RST = 4'h0;        // Auxiliary register
   localparam logic [3:0] PTR_HIGH_RST = 4'h0;   // ptr_high
   localparam logic [3:0] PTR_LOW_RST = 4'h0;    // ptr_low
   localparam logic CARRY_RST = 1'b0;            // carry_bit
   localparam logic ZERO_RST = 1'b0;             // zero_bit

   // Decimal correction addends
   localparam logic [3:0] BCD_ADD_K = 4'h6;      // bcd_fix_add addend
   localparam logic [3:0] BCD_SUB_K = 4'hA;      // bcd_fix_sub addend

   // Second byte of the shared compare prefix: this bit picks ptr_low
   localparam int CMP_SEL_BIT = 4;

   // Exact opcodes
   localparam logic [7:0] OP_ZERO_ACC = 8'hC0;
   localparam logic [7:0] OP_ZERO_CARRY = 8'hE1;
   localparam logic [7:0] OP_SET_CARRY = 8'hF1;
   localparam logic [7:0] OP_INVERT_ACC = 8'hEB;
   localparam logic [7:0] OP_ACC_PLUS_ONE = 8'h0E;
   localparam logic [7:0] OP_ACC_MINUS_ONE = 8'h0F;
   localparam logic [7:0] OP_ROTATE_ACC_LEFT = 8'h01;
   localparam logic [7:0] OP_COPY_ACC_TO_AUX = 8'h03;
   localparam logic [7:0] OP_SWAP_ACC_AUX = 8'h0D;
   localparam logic [7:0] OP_RAM_PLUS_ONE = 8'h2E;
   localparam logic [7:0] OP_RAM_MINUS_ONE = 8'h2F;
   localparam logic [7:0] OP_SUM_RAM = 8'h60;
   localparam logic [7:0] OP_SUM_RAM_CARRY = 8'h20;
   localparam logic [7:0] OP_BCD_FIX_ADD = 8'hE6;
   localparam logic [7:0] OP_BCD_FIX_SUB = 8'hEA;
   localparam logic [7:0] OP_XOR_RAM = 8'hF5;
   localparam logic [7:0] OP_AND_RAM = 8'hE7;
   localparam logic [7:0] OP_OR_RAM = 8'hE5;
   localparam logic [7:0] OP_COMPARE_RAM = 8'hFB;
   localparam logic [7:0] OP_COMPARE_PREFIX = 8'h2C;
   localparam logic [7:0] OP_STORE_RAM = 8'h02;
   localparam logic [7:0] OP_LOAD_RAM = 8'h21;
   localparam logic [7:0] OP_SWAP_RAM_STEP_UP = 8'hFE;
   localparam logic [7:0] OP_SWAP_RAM_STEP_DOWN = 8'hFF;
   localparam logic [7:0] OP_ROM_LOOKUP = 8'h63;
   localparam logic [7:0] OP_PTR_LOW_UP = 8'hEE;
   localparam logic [7:0] OP_PTR_LOW_DOWN = 8'hEF;

   // Opcodes with an operand field (? bits are wildcards in casez)
   localparam logic [7:0] OP_RAM_BIT_SET = 8'b0000_10??;
   localparam logic [7:0] OP_RAM_BIT_CLEAR = 8'b0010_10??;
   localparam logic [7:0] OP_LOAD_IMM = 8'b1100_????;
   localparam logic [7:0] OP_SWAP_RAM_OR_HIGH = 8'b1010_0???;
   localparam logic [7:0] OP_PTR_ZERO_LOAD = 8'b1000_????;
   localparam logic [7:0] OP_PTR_HIGH_LOAD = 8'b0100_????;

   // Sequencer states
   typedef enum logic [1:0] {
      NIB_ST_IDLE,                               // Takes a first byte
      NIB_ST_IMM,                                // Waits for the compare immediate
      NIB_ST_HOLD                                // Second cycle of a two-cycle op
   } nib_state_t;

endpackage : nib_pkg

`default_nettype wire

// >>> nib_alu_if.sv
// Carrier between the execute block and its 4-bit adder.
// Assumes the user side drives operands combinationally.
`default_nettype none

interface nib_alu_if;
   logic [3:0] a;      // First operand
   logic [3:0] b;      // Second operand
   logic cin;          // Carry into bit 0
   logic [3:0] sum;    // Sum modulo sixteen
   logic cout;         // Carry out of bit 3

   modport user (output a, output b, output cin, input sum, input cout);
   modport unit (input a, input b, input cin, output sum, output cout);
endinterface : nib_alu_if

`default_nettype wire

// >>> nib_alu.sv
// Shared 4-bit adder of the nibble execute block.
// Assumes purely combinational use within one clock cycle.
`default_nettype none

module nib_alu
   import nib_pkg::*;
(
   nib_alu_if.unit bus   // Operands in, sum and carry out
);

   logic [4:0] total;    // Sum with carry out of bit 3

   // Wraps modulo sixteen, carry is bit 4
   always_comb begin
      total = {1'b0, bus.a} + {1'b0, bus.b} + {4'h0, bus.cin};
      bus.sum = total[3:0];
      bus.cout = total[4];
   end

endmodule : nib_alu

`default_nettype wire

// >>> nib_exec_props.sv
// Port-level properties of the nibble execute block.
// Assumes it is bound into nib_exec and sees only that module's ports.
`default_nettype none
module nib_exec_props
   import nib_pkg::*;
#(
   parameter int RAM_DEPTH = 256 // Nibbles of working RAM
)(
   input wire logic clk_i, // Clock
   input wire logic reset_n_i, // Reset, active low
   input wire logic instr_valid_i, // Byte present
   input wire logic [7:0] instr_i, // Byte
   input wire logic instr_ready_o, // Byte can be taken
   input wire logic [PAGE_W-1:0] rom_page_i, // Page
   input wire logic [PAGE_W+ROM_W-1:0] rom_addr_o, // Lookup address
   input wire logic [ROM_W-1:0] rom_data_i, // ROM word
   input wire logic [3:0] acc_o, // Accumulator
   input wire logic [3:0] aux_o, // Auxiliary
   input wire logic [3:0] ptr_high_o, // ptr_high
   input wire logic [3:0] ptr_low_o, // ptr_low
   input wire logic carry_bit_o, // carry_bit
   input wire logic zero_bit_o // zero_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pend_r, pend_nxt; // Next taken byte is a compare immediate, not an opcode
   logic tk, two; // Opcode byte taken, and it needs a hold cycle
   assign tk = instr_valid_i && instr_ready_o && !pend_r;
   assign two = instr_i inside {OP_SWAP_RAM_STEP_UP, OP_SWAP_RAM_STEP_DOWN, OP_ROM_LOOKUP}
      || instr_i[7:3] == 5'b10100;
   // Without this an immediate byte would be read as an opcode
   always_comb begin
      pend_nxt = pend_r;
      if (instr_valid_i && instr_ready_o) pend_nxt = tk && instr_i == OP_COMPARE_PREFIX;
   end
   // Register the prefix tracker
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) pend_r <= 1'b0;
      else pend_r <= pend_nxt;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   property p_clr; tk && instr_i == OP_ZERO_ACC |=> acc_o == 4'h0 && zero_bit_o; endproperty
   a_clr: assert property (p_clr) else $error("acc not cleared");
   property p_cy; tk && instr_i inside {8'hE1, 8'hF1} |=> carry_bit_o == $past(instr_i[4]);
   endproperty
   a_cy: assert property (p_cy) else $error("carry op wrong");
   property p_inv; tk && instr_i == OP_INVERT_ACC |=> acc_o == ~$past(acc_o); endproperty
   a_inv: assert property (p_inv) else $error("complement wrong");
   property p_inc; tk && instr_i == OP_ACC_PLUS_ONE
      |=> {carry_bit_o, acc_o} == {1'b0, $past(acc_o)} + 5'h01; endproperty
   a_inc: assert property (p_inc) else $error("increment wrong");
   property p_rot; tk && instr_i == OP_ROTATE_ACC_LEFT
      |=> {carry_bit_o, acc_o} == {$past(acc_o), $past(carry_bit_o)}; endproperty
   a_rot: assert property (p_rot) else $error("rotate wrong");
   property p_xch; tk && instr_i == OP_SWAP_ACC_AUX |=> acc_o == $past(aux_o)
      && aux_o == $past(acc_o) && $stable(zero_bit_o); endproperty
   a_xch: assert property (p_xch) else $error("acc aux swap wrong");
   property p_bcd; tk && instr_i == OP_BCD_FIX_ADD
      |=> acc_o == $past(acc_o) + 4'h6 && $stable(carry_bit_o); endproperty
   a_bcd: assert property (p_bcd) else $error("decimal fix wrong");
   property p_ptr_zero; tk && instr_i[7:4] == 4'h8
      |=> ptr_high_o == 4'h0 && ptr_low_o == $past(instr_i[3:0]); endproperty
   a_ptr_zero: assert property (p_ptr_zero) else $error("pointer load wrong");
   property p_hold; tk && two |=> !instr_ready_o ##1 instr_ready_o; endproperty
   a_hold: assert property (p_hold) else $error("hold cycle wrong");
   property p_rom; tk && instr_i == OP_ROM_LOOKUP
      |=> rom_addr_o == {$past(rom_page_i), $past(aux_o), $past(acc_o)}
      ##1 {aux_o, acc_o} == $past(rom_data_i); endproperty
   a_rom: assert property (p_rom) else $error("table lookup wrong");
   c_rom: cover property (tk && instr_i == OP_ROM_LOOKUP);
   c_cmp: cover property (pend_r && instr_valid_i && instr_ready_o);
   c_swap_or: cover property (tk && instr_i[7:3] == 5'b10100);
endmodule : nib_exec_props
bind nib_exec nib_exec_props #(.RAM_DEPTH(RAM_DEPTH)) i_props (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
   .instr_ready_o(instr_ready_o), .rom_page_i(rom_page_i), .rom_addr_o(rom_addr_o),
   .rom_data_i(rom_data_i), .acc_o(acc_o), .aux_o(aux_o), .ptr_high_o(ptr_high_o),
   .ptr_low_o(ptr_low_o), .carry_bit_o(carry_bit_o), .zero_bit_o(zero_bit_o));
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the nibble execute block with a reference model.
// Assumes nib_exec_props is compiled alongside and bound into the design.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [3:0] acc, aux, ph, pl;
      logic c, z;
      logic [11:0] addr;
   } nib_note_t; // Expected outputs after one instruction
   logic clk_i = 1'b0, reset_n_i = 1'b0, instr_valid_i = 1'b0; // Clock, reset, valid
   logic [7:0] instr_i = 8'h00, rom_data_i = 8'h00; // Byte and ROM word
   logic [3:0] rom_page_i = 4'h0; // Program page
   logic instr_ready_o, carry_bit_o, zero_bit_o; // Design outputs
   logic [11:0] rom_addr_o; // Lookup address
   logic [3:0] acc_o, aux_o, ptr_high_o, ptr_low_o; // Design registers
   nib_note_t mdl = '0, exp_n; // Reference state and note under compare
   nib_note_t notes[$]; // Expected results, oldest first
   logic [3:0] ram[256]; // Reference RAM; filled before any read
   logic pend = 1'b0; // Next byte is a compare immediate
   int seed = 32'hdf16900c, n_errors = 0, total_checks = 0;
   always #50 clk_i = ~clk_i;
   nib_exec #(.RAM_DEPTH(256)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
      .rom_page_i(rom_page_i), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
      .acc_o(acc_o), .aux_o(aux_o), .ptr_high_o(ptr_high_o), .ptr_low_o(ptr_low_o),
      .carry_bit_o(carry_bit_o), .zero_bit_o(zero_bit_o));
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] want);
      total_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic final_report;
      if (n_errors == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic az(input logic [3:0] v);
      mdl.acc = v;
      mdl.z = (v == 4'h0);
   endtask : az
   task automatic acs(input logic [4:0] s);
      mdl.c = s[4];
      az(s[3:0]);
   endtask : acs
   // Reference model: one byte in, expected state out
   task automatic model(input logic [7:0] b, input logic [3:0] pg, input logic [7:0] rd);
      logic [4:0] s;
      logic [3:0] m;
      m = ram[{mdl.ph, mdl.pl}];
      s = {1'b0, m} + {1'b0, ~mdl.acc} + 5'h01;
      if (pend) begin
         pend = 1'b0;
         mdl.z = b[4] ? (mdl.pl == b[3:0]) : ({1'b0, b[3:0]} + {1'b0, ~mdl.acc} + 5'h01) == 5'h10;
         mdl.c = b[4] ? mdl.c : ({1'b0, b[3:0]} + {1'b0, ~mdl.acc} + 5'h01) > 5'h0F;
      end else casez (b)
         8'hE1, 8'hF1: mdl.c = b[4];
         8'hEB: az(~mdl.acc);
         8'h0E, 8'h0F: acs({1'b0, mdl.acc} + (b[0] ? 5'h0F : 5'h01));
         8'h01: acs({mdl.acc, mdl.c});
         8'h03: mdl.aux = mdl.acc;
         8'h0D: {mdl.acc, mdl.aux} = {mdl.aux, mdl.acc};
         8'h2E, 8'h2F: begin
            s = {1'b0, m} + (b[0] ? 5'h0F : 5'h01);
            ram[{mdl.ph, mdl.pl}] = s[3:0];
            {mdl.c, mdl.z} = {s[4], s[3:0] == 4'h0};
         end
         8'b0000_10??: ram[{mdl.ph, mdl.pl}][b[1:0]] = 1'b1;
         8'b0010_10??: begin
            m[b[1:0]] = 1'b0;
            ram[{mdl.ph, mdl.pl}] = m;
            mdl.z = (m == 4'h0);
         end
         8'h60, 8'h20: acs({1'b0, mdl.acc} + {1'b0, m} + {4'h0, !b[6] && mdl.c});
         8'hE6, 8'hEA: az(mdl.acc + (b[3] ? 4'hA : 4'h6));
         8'hF5: az(mdl.acc ^ m);
         8'hE7: az(mdl.acc & m);
         8'hE5: az(mdl.acc | m);
         8'hFB: {mdl.c, mdl.z} = {s[4], s[3:0] == 4'h0};
         8'h2C: pend = 1'b1;
         8'b1100_????: az(b[3:0]);
         8'h02: ram[{mdl.ph, mdl.pl}] = mdl.acc;
         8'h21: az(m);
         8'b1010_0???, 8'hFE, 8'hFF: begin
            ram[{mdl.ph, mdl.pl}] = mdl.acc;
            mdl.acc = m;
            mdl.ph = b[6] ? mdl.ph : (mdl.ph | {1'b0, b[2:0]});
            mdl.pl = b[6] ? mdl.pl + (b[0] ? 4'hF : 4'h1) : mdl.pl;
            mdl.z = ((b[6] ? mdl.pl : mdl.ph) == 4'h0);
         end
         8'h63: {mdl.addr, mdl.aux, mdl.acc} = {pg, mdl.aux, mdl.acc, rd};
         8'b1000_????: {mdl.ph, mdl.pl} = {4'h0, b[3:0]};
         8'b0100_????: mdl.ph = b[3:0];
         8'hEE, 8'hEF: begin
            mdl.pl = mdl.pl + (b[0] ? 4'hF : 4'h1);
            mdl.z = (mdl.pl == 4'h0);
         end
         default: ;
      endcase
   endtask : model
   // Present one byte; the hold cycle of two-cycle ops is left idle
   task automatic send(input logic [7:0] b);
      logic [3:0] pg;
      logic [7:0] rd;
      logic two;
      pg = 4'($random(seed));
      rd = 8'($random(seed));
      two = !pend && (b inside {8'hFE, 8'hFF, 8'h63} || b[7:3] == 5'b10100);
      instr_valid_i <= 1'b1;
      instr_i <= b;
      rom_page_i <= pg;
      model(b, pg, rd);
      @(posedge clk_i);
      if (two) begin
         instr_valid_i <= 1'b0;
         rom_data_i <= rd;
         @(posedge clk_i);
      end
      notes.push_back(mdl);
   endtask : send
   // Compare settled outputs against the oldest note
   always @(negedge clk_i) begin
      if (notes.size() > 0) begin
         exp_n = notes.pop_front();
         check("acc", 12'(acc_o), 12'(exp_n.acc));
         check("aux", 12'(aux_o), 12'(exp_n.aux));
         check("ptr_high", 12'(ptr_high_o), 12'(exp_n.ph));
         check("ptr_low", 12'(ptr_low_o), 12'(exp_n.pl));
         check("carry", 12'(carry_bit_o), 12'(exp_n.c));
         check("zero", 12'(zero_bit_o), 12'(exp_n.z));
         check("rom_addr", rom_addr_o, exp_n.addr);
         check("ready", 12'(instr_ready_o), 12'h001);
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      notes.push_back(mdl);
      // Fill every RAM nibble through pointer loads and stores
      for (int i = 0; i < 256; i++) begin
         send({4'h8, i[3:0]});
         send({4'h4, i[7:4]});
         send({4'hC, 4'($random(seed))});
         send(8'h02);
      end
      repeat (1500) send(8'($random(seed)));
      // Reset in mid-run: registers clear, RAM keeps its contents
      reset_n_i <= 1'b0;
      instr_valid_i <= 1'b0;
      @(posedge clk_i);
      mdl = '0;
      pend = 1'b0;
      notes.push_back(mdl);
      reset_n_i <= 1'b1;
      send(8'h21);
      send(8'h63);
      @(posedge clk_i);
      final_report;
   end
   initial begin
      repeat (10000) @(posedge clk_i);
      n_errors++;
      final_report;
   end
endmodule : tb_top
`default_nettype wire
